// ==== hw/fls_cyc.sv ====
// Bus-cycle engine: one read or write cycle on the flash pins per request.
// Assumes a request only arrives while no cycle is running.
`include "fls_regs.svh"
module fls_cyc import fls_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Sequencer side
  fls_cyc_if.eng cyc,
  // Flash pins
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [15:0] o_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_oe_n
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam int RWAIT = `FLS_ACC_CYC + `FLS_SYNC_CYC;
  fls_cyc_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;       // Phase counter
  logic wr_r, wr_nxt;               // Current cycle is a write
  logic ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
  logic [15:0] addr_r, addr_nxt, dq_r, dq_nxt, rd_r, rd_nxt;
  logic dq_oe_n_r, dq_oe_n_nxt, done_r, done_nxt;
  logic [15:0] dq_s1_r, dq_s2_r;    // Pin synchroniser

  // Next-state logic for one bus cycle
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    addr_nxt = addr_r;
    dq_nxt = dq_r;
    dq_oe_n_nxt = dq_oe_n_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    case (st_r)
      FLS_CY_IDLE: begin
        if (cyc.req) begin
          // Address set up before the write strobe falls; on a read the output gate falls with it
          addr_nxt = cyc.addr; // R2
          wr_nxt = cyc.wr;
          ce_n_nxt = 1'b0;
          cnt_nxt = 4'h0;
          if (cyc.wr) begin
            dq_nxt = cyc.wdata; // R19
            dq_oe_n_nxt = 1'b0;
            st_nxt = FLS_CY_SETUP;
          end else begin
            oe_n_nxt = 1'b0; // R3
            st_nxt = FLS_CY_RWAIT;
          end
        end
      end
      FLS_CY_SETUP: begin
        // Write strobe only under chip select, output gate high
        we_n_nxt = 1'b0; // R1
        st_nxt = FLS_CY_STROBE;
      end
      FLS_CY_STROBE: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == 4'(`FLS_PULSE_CYC - 1)) begin
          we_n_nxt = 1'b1; // R2
          st_nxt = FLS_CY_HOLD;
        end
      end
      FLS_CY_HOLD: begin
        // Data held through the write strobe rise, then deselect
        ce_n_nxt = 1'b1; // R4
        dq_oe_n_nxt = 1'b1;
        done_nxt = 1'b1;
        st_nxt = FLS_CY_IDLE;
      end
      FLS_CY_RWAIT: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == 4'(RWAIT - 1)) begin
          rd_nxt = dq_s2_r;
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          done_nxt = 1'b1;
          st_nxt = FLS_CY_IDLE;
        end
      end
      default: st_nxt = FLS_CY_IDLE;
    endcase
  end

  // Registers of the engine and pin synchroniser
  always_ff @(posedge i_clk) begin
    dq_s1_r <= i_dq;
    dq_s2_r <= dq_s1_r;
    if (i_reset) begin
      st_r <= FLS_CY_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      addr_r <= 16'h0000;
      dq_r <= 16'h0000;
      dq_oe_n_r <= 1'b1;
      rd_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      addr_r <= addr_nxt;
      dq_r <= dq_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end

  // Outputs from flops
  assign o_ce_n = ce_n_r;
  assign o_oe_n = oe_n_r;
  assign o_we_n = we_n_r;
  assign o_addr = addr_r;
  assign o_dq = dq_r;
  assign o_dq_oe_n = dq_oe_n_r;
  assign cyc.done = done_r;
  assign cyc.rdata = rd_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_we_under_ce: assert property (!we_n_r |-> !ce_n_r) // R1
    else $error("write strobe low without chip select");
  a_we_oe_excl: assert property (!(!we_n_r && !oe_n_r)) // R20
    else $error("write strobe and output gate low together");
  a_read_release: assert property (!oe_n_r |-> dq_oe_n_r) // R3
    else $error("controller drives data bus during read");
  a_strobe_stable: assert property (!we_n_r && $past(!we_n_r) |->
    $stable(addr_r) && $stable(dq_r)) // R2
    else $error("address or data moved under write strobe");
  a_data_hold: assert property ($rose(we_n_r) |-> !dq_oe_n_r && !ce_n_r) // R2
    else $error("data released before write strobe rise");
  a_cycle_bound: assert property (cyc.req && st_r == FLS_CY_IDLE |->
    ##[3:12] done_r) // R1
    else $error("bus cycle did not finish in time");
endmodule // fls_cyc

// ==== hw/fls_cyc_if.sv ====
// Carrier between the operation sequencer and the bus-cycle engine.
// Assumes both ends run on the same clock.
interface fls_cyc_if;
  logic req;          // One-cycle request for a bus cycle
  logic wr;           // High for a write cycle
  logic [15:0] addr;  // Cycle address
  logic [15:0] wdata; // Write data
  logic done;         // One-cycle pulse when the cycle has ended
  logic [15:0] rdata; // Read data, valid with done

  modport seq (output req, output wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output done, output rdata);
endinterface

// ==== hw/fls_host.sv ====
// Host controller for a 64K x16 asynchronous NOR flash: reads, protected
// word programming, sector and chip erase with status polling.
// Assumes the flash pins connect straight to the device; the data bus
// wire is resolved outside from o_dq and o_dq_oe_n.
// Notes on behaviour
// (R1) Write strobe pulses only under chip select.
// (R2) Address before strobe falls, data past rise.
// (R3) Device drives data only when selected, gated.
// (R4) Chip select high leaves device in standby.
// (R5) Host programs single words into erased sectors.
// (R6) Program: three unlock cycles, then address/data.
// (R7) Program finishes within twenty microseconds.
// (R8) While busy, only status reads; commands ignored.
// (R9) Sector erase: six cycles, sector in A15-A11.
// (R10) Sector address and code latched on sixth.
// (R11) Chip erase: six cycles, code at fixed address.
// (R12) Chip erase starts at sixth strobe rise.
// (R13) Status reporting enabled after launching strobe.
// (R14) Program busy: inverted data bit inverted.
// (R15) Erase busy: bit reads zero, then one.
// (R16) Status valid after fourth or sixth pulse.
// (R17) Alternating bit toggles while busy, then stops.
// (R18) Doubtful completion: reread twice, both valid.
// (R19) Invalid cycle aborts; upper data byte ignored.
// (R20) Writes inhibited with gate low or strobes high.
// (R21) After completion, device returns to read mode.
`include "fls_regs.svh"
module fls_host import fls_pkg::*; #(
  parameter int ERASE_LIMIT = `FLS_ERASE_CYC // Erase poll limit, cycles
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Command port
  input wire logic i_cmd_valid,
  input wire logic [1:0] i_cmd_op,
  input wire logic [15:0] i_cmd_addr,
  input wire logic [15:0] i_cmd_data,
  output logic o_cmd_ready,
  output logic o_done,
  output logic o_timeout,
  output logic [15:0] o_rd_data,
  // Flash pins
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [15:0] o_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_oe_n
);
  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  localparam int PROG_LIMIT = `FLS_PROG_CYC + `FLS_POLL_SLACK;
  if (ERASE_LIMIT < PROG_LIMIT) begin : g_bad_limit
    $error("ERASE_LIMIT too small");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  fls_cyc_if cyc();
  fls_seq_type st_r, st_nxt;
  fls_op_type op_r, op_nxt;              // Operation in flight
  logic [15:0] addr_r, addr_nxt;         // Target address
  logic [15:0] data_r, data_nxt;         // Program data
  logic [2:0] step_r, step_nxt;          // Command cycle index
  logic req_r, req_nxt;                  // Engine request
  logic [15:0] ca_r, ca_nxt, cd_r, cd_nxt; // Cycle address and data
  logic cw_r, cw_nxt;                    // Cycle is a write
  logic prev_alt_r, prev_alt_nxt;        // Last alternating bit seen
  logic have_prev_r, have_prev_nxt;      // A status read is held
  logic [1:0] good_r, good_nxt;          // Quiet rereads so far
  logic [31:0] tmo_r, tmo_nxt;           // Poll time counter
  logic ready_r, ready_nxt, done_r, done_nxt, tmo_flag_r, tmo_flag_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic [15:0] sa, sd;                   // Sequence cycle address/data
  logic last_step, inv_ok, quiet;

  // Command table: unlock cycles followed by the operation cycle
  always_comb begin
    sa = `FLS_UNLOCK_ADDR1;
    sd = `FLS_UNLOCK_DATA1;
    last_step = 1'b0;
    case (step_r)
      3'h0: sd = `FLS_UNLOCK_DATA1;
      3'h1: begin
        sa = `FLS_UNLOCK_ADDR2;
        sd = `FLS_UNLOCK_DATA2;
      end
      3'h2: sd = (op_r == FLS_OP_PROG) ? `FLS_CODE_PROG : `FLS_CODE_ERASE;
      3'h3: begin
        if (op_r == FLS_OP_PROG) begin
          sa = addr_r; // R6
          sd = data_r; // R5
          last_step = 1'b1;
        end
      end
      3'h4: begin
        sa = `FLS_UNLOCK_ADDR2;
        sd = `FLS_UNLOCK_DATA2;
      end
      3'h5: begin
        last_step = 1'b1;
        if (op_r == FLS_OP_SECTOR) begin
          sa = addr_r & `FLS_SECTOR_MASK; // R9
          sd = `FLS_CODE_SECTOR; // R10
        end else begin
          sa = `FLS_CHIP_ADDR; // R11
          sd = `FLS_CODE_CHIP; // R12
        end
      end
      default: sd = `FLS_UNLOCK_DATA1;
    endcase
  end

  // Status qualifiers of a poll read
  always_comb begin
    // Program: true bit 7 on completion; erase: reads one
    inv_ok = (op_r == FLS_OP_PROG) ? // R14
      (cyc.rdata[`FLS_BIT_INV] == data_r[`FLS_BIT_INV]) :
      cyc.rdata[`FLS_BIT_INV]; // R15
    // Alternating bit stopped since the previous read
    quiet = have_prev_r && (cyc.rdata[`FLS_BIT_ALT] == prev_alt_r); // R17
  end

  // Sequencer next-state logic
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    step_nxt = step_r;
    req_nxt = 1'b0;
    ca_nxt = ca_r;
    cd_nxt = cd_r;
    cw_nxt = cw_r;
    prev_alt_nxt = prev_alt_r;
    have_prev_nxt = have_prev_r;
    good_nxt = good_r;
    tmo_nxt = tmo_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    tmo_flag_nxt = tmo_flag_r;
    rd_nxt = rd_r;
    case (st_r)
      FLS_SQ_IDLE: begin
        if (i_cmd_valid && ready_r) begin
          op_nxt = fls_op_type'(i_cmd_op);
          addr_nxt = i_cmd_addr;
          data_nxt = i_cmd_data;
          step_nxt = 3'h0;
          ready_nxt = 1'b0;
          tmo_flag_nxt = 1'b0;
          req_nxt = 1'b1;
          if (fls_op_type'(i_cmd_op) == FLS_OP_READ) begin
            ca_nxt = i_cmd_addr;
            cw_nxt = 1'b0;
            st_nxt = FLS_SQ_READ;
          end else begin
            ca_nxt = `FLS_UNLOCK_ADDR1;
            cd_nxt = `FLS_UNLOCK_DATA1;
            cw_nxt = 1'b1;
            st_nxt = FLS_SQ_WRITE;
          end
        end
      end
      FLS_SQ_WRITE: begin
        if (cyc.done) begin
          if (last_step) begin
            // Launching strobe has risen: status reporting is live
            have_prev_nxt = 1'b0; // R13
            good_nxt = 2'h0;
            tmo_nxt = 32'h0;
            cw_nxt = 1'b0;
            ca_nxt = addr_r;
            req_nxt = 1'b1;
            st_nxt = FLS_SQ_POLL; // R16
          end else begin
            step_nxt = step_r + 3'h1;
            req_nxt = 1'b1;
            st_nxt = FLS_SQ_WRITE;
          end
        end
      end
      FLS_SQ_POLL: begin
        // Only status reads while the device is busy
        tmo_nxt = tmo_r + 32'h1; // R8
        if (cyc.done) begin
          prev_alt_nxt = cyc.rdata[`FLS_BIT_ALT];
          have_prev_nxt = 1'b1;
          rd_nxt = cyc.rdata;
          if (quiet && inv_ok) begin
            good_nxt = good_r + 2'h1; // R18
          end else begin
            good_nxt = 2'h0;
          end
          if (quiet && inv_ok && good_r == 2'(`FLS_CONFIRM)) begin
            // Completion confirmed; device back in read mode
            done_nxt = 1'b1; // R21
            ready_nxt = 1'b1;
            st_nxt = FLS_SQ_IDLE;
          end else if (tmo_r >= ((op_r == FLS_OP_PROG) ? // R7
                     32'(PROG_LIMIT) : 32'(ERASE_LIMIT))) begin
            tmo_flag_nxt = 1'b1;
            done_nxt = 1'b1;
            ready_nxt = 1'b1;
            st_nxt = FLS_SQ_IDLE;
          end else begin
            req_nxt = 1'b1;
          end
        end
      end
      FLS_SQ_READ: begin
        if (cyc.done) begin
          rd_nxt = cyc.rdata; // R3
          done_nxt = 1'b1;
          ready_nxt = 1'b1;
          st_nxt = FLS_SQ_IDLE;
        end
      end
      default: st_nxt = FLS_SQ_IDLE;
    endcase
    // Cycle address follows the step that is about to run
    if (st_r == FLS_SQ_WRITE && cyc.done && !last_step) begin
      ca_nxt = (step_r == 3'h0 || step_r == 3'h3) ? `FLS_UNLOCK_ADDR2 : `FLS_UNLOCK_ADDR1;
    end
  end

  // Command table output for the next write step
  logic [15:0] nsa, nsd;
  always_comb begin
    nsa = sa;
    nsd = sd;
  end

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= FLS_SQ_IDLE;
      op_r <= FLS_OP_READ;
      addr_r <= 16'h0000;
      data_r <= 16'h0000;
      step_r <= 3'h0;
      req_r <= 1'b0;
      ca_r <= 16'h0000;
      cd_r <= 16'h0000;
      cw_r <= 1'b0;
      prev_alt_r <= 1'b0;
      have_prev_r <= 1'b0;
      good_r <= 2'h0;
      tmo_r <= 32'h0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      tmo_flag_r <= 1'b0;
      rd_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      step_r <= step_nxt;
      req_r <= req_nxt;
      ca_r <= ca_nxt;
      cd_r <= cd_nxt;
      cw_r <= cw_nxt;
      prev_alt_r <= prev_alt_nxt;
      have_prev_r <= have_prev_nxt;
      good_r <= good_nxt;
      tmo_r <= tmo_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      tmo_flag_r <= tmo_flag_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Engine request: write steps take address/data from the table
  assign cyc.req = req_r;
  assign cyc.wr = cw_r;
  assign cyc.addr = (st_r == FLS_SQ_WRITE) ? nsa : ca_r;
  assign cyc.wdata = (st_r == FLS_SQ_WRITE) ? nsd : cd_r;

  // ----------------------------------------------------------------------
  // Bus-cycle engine
  // ----------------------------------------------------------------------
  fls_cyc u_cyc (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .cyc(cyc.eng),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_addr(o_addr),
    .i_dq(i_dq),
    .o_dq(o_dq),
    .o_dq_oe_n(o_dq_oe_n)
  );

  assign o_cmd_ready = ready_r;
  assign o_done = done_r;
  assign o_timeout = tmo_flag_r;
  assign o_rd_data = rd_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_prog_len: assert property (st_r == FLS_SQ_WRITE && op_r == FLS_OP_PROG &&
    last_step |-> step_r == 3'(`FLS_PROG_LEN - 1)) // R6
    else $error("program sequence length wrong");
  a_erase_len: assert property (st_r == FLS_SQ_WRITE && op_r != FLS_OP_PROG &&
    last_step |-> step_r == 3'(`FLS_ERASE_LEN - 1)) // R9
    else $error("erase sequence length wrong");
  a_done_ready: assert property (done_r |-> ready_r && st_r == FLS_SQ_IDLE) // R21
    else $error("done without return to idle");
  a_busy_no_cmd: assert property (st_r == FLS_SQ_POLL |-> !cyc.wr || !cyc.req) // R8
    else $error("write issued while device busy");
  a_poll_confirm: assert property ($rose(done_r) && $past(st_r) == FLS_SQ_POLL &&
    !tmo_flag_r |-> $past(good_r) == 2'(`FLS_CONFIRM)) // R18
    else $error("completion taken without two rereads");
  c_program: cover property (op_r == FLS_OP_PROG && done_r && !tmo_flag_r);
  c_sector: cover property (op_r == FLS_OP_SECTOR && done_r);
  c_timeout: cover property (tmo_flag_r && done_r);
endmodule // fls_host

// ==== hw/fls_pkg.sv ====
// Types shared by the flash host controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package fls_pkg;

  // ----------------------------------------------------------------------
  // Host operations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FLS_OP_READ = 2'h0,
    FLS_OP_PROG = 2'h1,
    FLS_OP_SECTOR = 2'h2,
    FLS_OP_CHIP = 2'h3
  } fls_op_type;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    FLS_SQ_IDLE = 4'h1,
    FLS_SQ_WRITE = 4'h2,
    FLS_SQ_POLL = 4'h4,
    FLS_SQ_READ = 4'h8
  } fls_seq_type;

  // Bus-cycle engine states, one-hot
  typedef enum logic [4:0] {
    FLS_CY_IDLE = 5'h01,
    FLS_CY_SETUP = 5'h02,
    FLS_CY_STROBE = 5'h04,
    FLS_CY_HOLD = 5'h08,
    FLS_CY_RWAIT = 5'h10
  } fls_cyc_type;

endpackage

// ==== hw/fls_regs.svh ====
// Timing figures and command codes for the parallel flash host controller.
// Assumes the controller clock runs at the rate named by FLS_CLK_NS.
`ifndef FLS_REGS_SVH
`define FLS_REGS_SVH

// ----------------------------------------------------------------------
// Clock and bus-cycle timing
// ----------------------------------------------------------------------
`define FLS_CLK_NS 25
`define FLS_PULSE_NS 50
`define FLS_PULSE_CYC ((`FLS_PULSE_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
`define FLS_ACC_NS 70
`define FLS_ACC_CYC ((`FLS_ACC_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
`define FLS_SYNC_CYC 2
`define FLS_PROG_NS 20000
`define FLS_PROG_CYC (`FLS_PROG_NS / `FLS_CLK_NS)
`define FLS_POLL_SLACK 64
`define FLS_ERASE_CYC 4000000

// ----------------------------------------------------------------------
// Command codes and fixed addresses
// ----------------------------------------------------------------------
`define FLS_UNLOCK_ADDR1 16'h5555
`define FLS_UNLOCK_ADDR2 16'h2AAA
`define FLS_UNLOCK_DATA1 16'h00AA
`define FLS_UNLOCK_DATA2 16'h0055
`define FLS_CODE_PROG 16'h00A0
`define FLS_CODE_ERASE 16'h0080
`define FLS_CODE_SECTOR 16'h0030
`define FLS_CODE_CHIP 16'h0010
`define FLS_CHIP_ADDR 16'h5555
`define FLS_SECTOR_MASK 16'hF800
`define FLS_BIT_INV 7
`define FLS_BIT_ALT 6
`define FLS_PROG_LEN 4
`define FLS_ERASE_LEN 6
`define FLS_CONFIRM 2

`endif

// ==== testbench/fls_flash_model.sv ====
// Behavioural model of the 64K x16 NOR flash that the host controller drives.
// Assumes the bench resolves the shared data bus from the host's data enable.
`include "fls_regs.svh"
module fls_flash_model #(
  parameter int PROG_NS = 4000,  // Internal program time, below the 20 us limit
  parameter int ERASE_NS = 20000 // Internal erase time
) (
  // Flash pins
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_en,
  // Bench controls and observations
  input wire logic i_stuck,
  output int o_bad,
  output int o_pulses,
  output int o_late
);
  // ----------------------------------------------------------------------
  // Array and sequence state
  // ----------------------------------------------------------------------
  logic [15:0] mem [0:65535]; // Memory array
  logic [15:0] a_lat;         // Address latched at the write fall
  logic [15:0] pdata;         // Word under internal programming
  logic [15:0] rd;            // Read latch
  logic [15:0] val;           // Value the current read will show
  logic busy = 1'b0;          // Internal program or erase running
  logic erasing = 1'b0;       // Running operation is an erase
  logic tog = 1'b0;           // Alternating status bit
  logic wr_act = 1'b0;        // A write pulse is open
  logic ers = 1'b0;           // Sequence heads for an erase
  int step = 0;               // Sequence cycles accepted so far
  event kick;                 // Starts the busy timer

  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    o_bad = 0;
    o_pulses = 0;
    o_late = 0;
    rd = 16'h0000;
  end

  // Launch an internal operation; status reporting starts here
  task automatic launch(input logic e);
    busy = 1'b1;
    erasing = e;
    step = 0;
    -> kick;
  endtask

  // Sequence decoder; upper byte ignored, bad cycle returns to read mode
  task automatic take(input logic [15:0] a, input logic [15:0] d);
    if (busy) return;
    case (step)
      0, 3: begin
        if (step == 3 && !ers) begin
          pdata = d;
          mem[a] = mem[a] & d;
          launch(1'b0);
        end else begin
          step = (a == `FLS_UNLOCK_ADDR1 && d[7:0] == 8'hAA) ? step + 1 : 0;
        end
      end
      1, 4: step = (a == `FLS_UNLOCK_ADDR2 && d[7:0] == 8'h55) ? step + 1 : 0;
      2: begin
        ers = (d[7:0] == 8'h80);
        step = (a == `FLS_UNLOCK_ADDR1 && (ers || d[7:0] == 8'hA0)) ? 3 : 0;
      end
      default: begin
        step = 0;
        if (d[7:0] == 8'h30) begin
          for (int i = 0; i < 2048; i++) mem[{a[15:11], i[10:0]}] = 16'hFFFF;
          launch(1'b1);
        end else if (a == 16'h5555 && d[7:0] == 8'h10) begin
          foreach (mem[i]) mem[i] = 16'hFFFF;
          launch(1'b1);
        end
      end
    endcase
  endtask

  // ----------------------------------------------------------------------
  // Write cycles
  // ----------------------------------------------------------------------
  // Strobe under deselect is a host fault
  always @(negedge i_we_n) if (i_ce_n) o_bad++;

  // Address at the later falling edge; gate low inhibits the write
  always @(negedge i_we_n or negedge i_ce_n) begin
    if (!i_we_n && !i_ce_n) begin
      a_lat = i_addr;
      if (!i_oe_n) o_bad++;
      else wr_act = 1'b1;
    end
  end

  // Data at the earlier rising edge
  always @(posedge i_we_n or posedge i_ce_n) begin
    if (wr_act) begin
      wr_act = 1'b0;
      o_pulses++;
      take(a_lat, i_dq);
    end
  end

  // ----------------------------------------------------------------------
  // Read cycles
  // ----------------------------------------------------------------------
  // Status while busy, array data otherwise; the old value is garbled first
  always @(negedge i_oe_n or negedge i_ce_n) begin
    if (!i_oe_n && !i_ce_n) begin
      if (busy) tog = ~tog;
      else o_late++;
      val = busy ? {pdata[15:8], erasing ? 1'b0 : ~pdata[7], tog, pdata[5:0]} : mem[i_addr];
      rd = ~rd;
      rd <= #60 val;
    end
  end

  // Drive only while selected and gated; released bus shows inverted data
  assign o_dq_en = !i_ce_n && !i_oe_n;
  assign o_dq = o_dq_en ? rd : ~rd;

  // Busy timer, held off while the bench asks for a stuck device
  always @(kick) begin
    #(erasing ? ERASE_NS : PROG_NS);
    while (i_stuck) #100;
    o_late = 0;
    busy = 1'b0;
  end
endmodule // fls_flash_model

// ==== testbench/parallel_nor_flash_command_sequencer_tb_top.sv ====
// Self-checking bench for the flash host controller against a flash model.
// Assumes the model in fls_flash_model.sv and a 40 MHz clock.
module parallel_nor_flash_command_sequencer_tb_top import fls_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic valid = 1'b0;
  logic [1:0] cop = 2'h0;
  logic [15:0] caddr = 16'h0000;
  logic [15:0] cdata = 16'h0000;
  logic ready, done, tmo, ce_n, oe_n, we_n, dq_oe_n, dev_en;
  logic stuck = 1'b0;
  logic [15:0] rdata, addr, host_dq, dev_dq, dq_bus;
  int bad, pulses, late, fail_count = 0, tests_run = 0, cycles = 0;

  // Bus level from both drivers
  assign dq_bus = !dq_oe_n ? host_dq : dev_dq;

  fls_host #(.ERASE_LIMIT(2000)) u_dut (.i_clk(clk), .i_reset(rst), .i_cmd_valid(valid),
    .i_cmd_op(cop), .i_cmd_addr(caddr), .i_cmd_data(cdata), .o_cmd_ready(ready),
    .o_done(done), .o_timeout(tmo), .o_rd_data(rdata), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_we_n(we_n), .o_addr(addr), .i_dq(dq_bus), .o_dq(host_dq), .o_dq_oe_n(dq_oe_n));

  fls_flash_model u_flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr),
    .i_dq(dq_bus), .o_dq(dev_dq), .o_dq_en(dev_en), .i_stuck(stuck), .o_bad(bad),
    .o_pulses(pulses), .o_late(late));

  // Clock
  initial forever #12.5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One command, wait for the end pulse, judge pulses, timeout and polling
  task automatic run_op(input fls_op_type op, input logic [15:0] a, input logic [15:0] d,
                        input logic exp_to, input int exp_pulses);
    int n;
    int p0;
    p0 = pulses;
    @(negedge clk);
    valid = 1'b1;
    cop = op;
    caddr = a;
    cdata = d;
    do @(posedge clk); while (ready !== 1'b1);
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, done}, 16'h0001);
    check({15'h0000, tmo}, {15'h0000, exp_to});
    check(16'(pulses - p0), 16'(exp_pulses));
    if (op != FLS_OP_READ && !exp_to) check({15'h0000, late >= 3}, 16'h0001);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_program();
    logic [15:0] wa [2] = '{16'h1234, 16'h1800};
    logic [15:0] wd [2] = '{16'h5A3C, 16'hC3A5};
    for (int i = 0; i < 2; i++) begin
      run_op(FLS_OP_PROG, wa[i], wd[i], 1'b0, 4);
      check(rdata, wd[i]);
      run_op(FLS_OP_READ, wa[i], 16'h0000, 1'b0, 0);
      check(rdata, wd[i]);
    end
  endtask

  task automatic t_sector_erase();
    run_op(FLS_OP_SECTOR, 16'h17FF, 16'h0000, 1'b0, 6);
    check(rdata[7:0] & 8'h80, 16'h0080);
    run_op(FLS_OP_READ, 16'h1234, 16'h0000, 1'b0, 0);
    check(rdata, 16'hFFFF);
    run_op(FLS_OP_READ, 16'h1800, 16'h0000, 1'b0, 0);
    check(rdata, 16'hC3A5);
  endtask

  task automatic t_chip_erase();
    run_op(FLS_OP_CHIP, 16'h0000, 16'h0000, 1'b0, 6);
    run_op(FLS_OP_READ, 16'h1800, 16'h0000, 1'b0, 0);
    check(rdata, 16'hFFFF);
  endtask

  task automatic t_timeout();
    stuck = 1'b1;
    run_op(FLS_OP_PROG, 16'h0042, 16'h0011, 1'b1, 4);
    stuck = 1'b0;
    repeat (200) @(negedge clk);
    run_op(FLS_OP_READ, 16'h0042, 16'h0000, 1'b0, 0);
    check(rdata, 16'h0011);
  endtask

  // ----------------------------------------------------------------------
  // Watchdog and bus contention
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      print_verdict();
    end
  end

  always @(negedge clk) if (!dq_oe_n && dev_en) check(16'h0001, 16'h0000);

  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check({11'h000, ready, ce_n, oe_n, we_n, dq_oe_n}, 16'h001F);
    run_op(FLS_OP_READ, 16'h0100, 16'h0000, 1'b0, 0);
    check(rdata, 16'hFFFF);
    t_program();
    t_sector_erase();
    t_chip_erase();
    t_timeout();
    check(16'(bad), 16'h0000);
    print_verdict();
  end
endmodule // parallel_nor_flash_command_sequencer_tb_top
